// ==== hdl/led_ctrl_pkg.sv ====
// Constants for the LED driver mode, shutdown and spread control block.
// Assumes a single 20 MHz clock and register access over a two-wire serial bus.
// Behaviour
// - Range field selects four spread widths
// - PWM only, 256/1024/4096/65536 steps
// - Duty value maps linearly to steps
// - Shutdown keeps all register contents
// - Soft sleep bit zero enters software shutdown
// - Software shutdown darkens outputs, registers stay accessible
// - Power-down pin low disables analog circuitry
// - Pin rising edge resets serial engine only
// - Serial access works while pin low
// - Spread runs only when enable bit set
// - Cycle field 00..11 gives shorter periods
// - Zero write to reset register restores defaults, only with pin high and soft sleep bit set
package led_ctrl_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h00;
   localparam logic [7:0] OFS_DUTY_HIGH = 8'h01;
   localparam logic [7:0] OFS_DUTY_LOW = 8'h02;
   localparam logic [7:0] OFS_SPREAD_CONFIG = 8'h78;
   localparam logic [7:0] OFS_RESET_CMD = 8'h7f;
   localparam logic [7:0] RESET_CMD_VALUE = 8'h00;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int SOFT_SLEEP_N_BIT = 0;
   localparam int RES_SEL_LSB = 1;
   localparam int CYCLE_SEL_LSB = 0;
   localparam int RANGE_SEL_LSB = 2;
   localparam int SPREAD_EN_BIT = 4;
   localparam logic [7:0] RST_DEVICE_CONTROL = 8'h00;
   localparam logic [7:0] RST_DUTY = 8'h00;
   localparam logic [7:0] RST_SPREAD_CONFIG = 8'h00;
   localparam logic [6:0] DEFAULT_BUS_ADDR = 7'h34; // Arbitrary value.
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int SPREAD_T0_US = 1980;
   localparam int SPREAD_T1_US = 1200;
   localparam int SPREAD_T2_US = 820;
   localparam int SPREAD_T3_US = 660;
   localparam int SPREAD_T0_CYC = SPREAD_T0_US * CLK_MHZ;
   localparam int SPREAD_T1_CYC = SPREAD_T1_US * CLK_MHZ;
   localparam int SPREAD_T2_CYC = SPREAD_T2_US * CLK_MHZ;
   localparam int SPREAD_T3_CYC = SPREAD_T3_US * CLK_MHZ;
   localparam int SWEEP_STEPS = 512;
   localparam logic [7:0] SWEEP_CENTER = 8'h80;
endpackage

// ==== hdl/led_mode_ctrl.sv ====
// Mode, shutdown and spread control with a serial register slave.
// Assumes serial clock, data and power-down pin arrive asynchronously from outside.
`timescale 1ns/1ps
module led_mode_ctrl
#(
   parameter logic [6:0] BUS_ADDR = led_ctrl_pkg::DEFAULT_BUS_ADDR,
   parameter int SPREAD_T0_CYCLES = led_ctrl_pkg::SPREAD_T0_CYC,
   parameter int SPREAD_T1_CYCLES = led_ctrl_pkg::SPREAD_T1_CYC,
   parameter int SPREAD_T2_CYCLES = led_ctrl_pkg::SPREAD_T2_CYC,
   parameter int SPREAD_T3_CYCLES = led_ctrl_pkg::SPREAD_T3_CYC
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   input wire logic hw_power_down_n,
   output logic analogEnable,
   output logic ledEnable,
   output logic pwmOut,
   output logic spreadActive,
   output logic [1:0] spreadRange,
   output logic [7:0] sweepPhase
);
   if (SPREAD_T3_CYCLES < led_ctrl_pkg::SWEEP_STEPS || SPREAD_T0_CYCLES > 32'h00ffffff)
      $error("Spread period parameters out of range");

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001, ST_ADDR = 9'h002, ST_AACK = 9'h004, ST_PTR = 9'h008,
      ST_PACK = 9'h010, ST_WR = 9'h020, ST_WACK = 9'h040, ST_RD = 9'h080,
      ST_RACK = 9'h100
   } bus_state_e;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [2:0] sclSync, sdaSync, pdSync;
   logic sclRise, sclFall, startSeen, stopSeen, pdRise, pinHigh;

   // Third stage only serves edge detection; the first stage feeds nothing else.
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         sclSync <= 3'h7;
         sdaSync <= 3'h7;
         pdSync <= 3'h0;
      end
      else if (clkEn)
      begin
         sclSync <= {sclSync[1:0], sclIn};
         sdaSync <= {sdaSync[1:0], sdaIn};
         pdSync <= {pdSync[1:0], hw_power_down_n};
      end
   end

   assign sclRise = sclSync[1] & ~sclSync[2];
   assign sclFall = ~sclSync[1] & sclSync[2];
   assign startSeen = sclSync[1] & sclSync[2] & ~sdaSync[1] & sdaSync[2];
   assign stopSeen = sclSync[1] & sclSync[2] & sdaSync[1] & ~sdaSync[2];
   assign pdRise = pdSync[1] & ~pdSync[2];
   assign pinHigh = pdSync[1];

   // ----------------------------------------------------------------
   // Serial slave and register file
   // ----------------------------------------------------------------
   bus_state_e state, next_state;
   logic [7:0] shiftReg, next_shiftReg, regPtr, next_regPtr, readData;
   logic [3:0] bitCnt, next_bitCnt;
   logic readMode, next_readMode, nack, next_nack, next_sdaOeN;
   logic [7:0] control, next_control, spreadCfg, next_spreadCfg;
   logic [7:0] dutyHigh, next_dutyHigh, dutyLow, next_dutyLow;
   logic wrStrobe;

   // Read data mux; unmapped offsets read as zero.
   always_comb
   begin
      case (regPtr)
         led_ctrl_pkg::OFS_DEVICE_CONTROL: readData = control;
         led_ctrl_pkg::OFS_DUTY_HIGH: readData = dutyHigh;
         led_ctrl_pkg::OFS_DUTY_LOW: readData = dutyLow;
         led_ctrl_pkg::OFS_SPREAD_CONFIG: readData = spreadCfg;
         default: readData = 8'h00;
      endcase
   end

   // Bit engine acts on falling clock edges, sampling on rising ones.
   always_comb
   begin
      next_state = state;
      next_shiftReg = shiftReg;
      next_regPtr = regPtr;
      next_bitCnt = bitCnt;
      next_readMode = readMode;
      next_nack = nack;
      next_sdaOeN = sdaOeN;
      wrStrobe = 1'b0;
      if (pdRise)
      begin
         next_state = ST_IDLE;
         next_sdaOeN = 1'b1;
      end
      else if (startSeen)
      begin
         next_state = ST_ADDR;
         next_bitCnt = 4'h0;
         next_sdaOeN = 1'b1;
      end
      else if (stopSeen)
      begin
         next_state = ST_IDLE;
         next_sdaOeN = 1'b1;
      end
      else if (sclRise)
      begin
         if (state == ST_RACK)
            next_nack = sdaSync[1];
         else if (state inside {ST_ADDR, ST_PTR, ST_WR, ST_RD})
         begin
            next_bitCnt = bitCnt + 4'h1;
            if (state != ST_RD)
               next_shiftReg = {shiftReg[6:0], sdaSync[1]};
         end
      end
      else if (sclFall)
      begin
         case (state)
            ST_ADDR:
               if (bitCnt == 4'h8)
               begin
                  next_readMode = shiftReg[0];
                  next_state = (shiftReg[7:1] == BUS_ADDR) ? ST_AACK : ST_IDLE;
                  next_sdaOeN = (shiftReg[7:1] != BUS_ADDR);
               end
            ST_AACK:
            begin
               next_bitCnt = 4'h0;
               if (readMode)
               begin
                  next_state = ST_RD;
                  next_shiftReg = readData;
                  next_sdaOeN = readData[7];
                  next_regPtr = regPtr + 8'h01;
               end
               else
               begin
                  next_state = ST_PTR;
                  next_sdaOeN = 1'b1;
               end
            end
            ST_PTR:
               if (bitCnt == 4'h8)
               begin
                  next_regPtr = shiftReg;
                  next_state = ST_PACK;
                  next_sdaOeN = 1'b0;
               end
            ST_PACK, ST_WACK:
            begin
               next_state = ST_WR;
               next_bitCnt = 4'h0;
               next_sdaOeN = 1'b1;
            end
            ST_WR:
               if (bitCnt == 4'h8)
               begin
                  wrStrobe = 1'b1;
                  next_regPtr = regPtr + 8'h01;
                  next_state = ST_WACK;
                  next_sdaOeN = 1'b0;
               end
            ST_RD:
               if (bitCnt == 4'h8)
               begin
                  next_state = ST_RACK;
                  next_sdaOeN = 1'b1;
               end
               else
               begin
                  next_shiftReg = {shiftReg[6:0], 1'b0};
                  next_sdaOeN = shiftReg[6];
               end
            ST_RACK:
               if (nack)
                  next_state = ST_IDLE;
               else
               begin
                  next_state = ST_RD;
                  next_bitCnt = 4'h0;
                  next_shiftReg = readData;
                  next_sdaOeN = readData[7];
                  next_regPtr = regPtr + 8'h01;
               end
            default: next_state = state;
         endcase
      end
   end

   // Register writes; nothing else alters them, so shutdown keeps the settings.
   always_comb
   begin
      next_control = control;
      next_spreadCfg = spreadCfg;
      next_dutyHigh = dutyHigh;
      next_dutyLow = dutyLow;
      if (wrStrobe)
      begin
         case (regPtr)
            led_ctrl_pkg::OFS_DEVICE_CONTROL: next_control = shiftReg;
            led_ctrl_pkg::OFS_DUTY_HIGH: next_dutyHigh = shiftReg;
            led_ctrl_pkg::OFS_DUTY_LOW: next_dutyLow = shiftReg;
            led_ctrl_pkg::OFS_SPREAD_CONFIG: next_spreadCfg = shiftReg;
            led_ctrl_pkg::OFS_RESET_CMD:
               if (shiftReg == led_ctrl_pkg::RESET_CMD_VALUE && pinHigh
                   && control[led_ctrl_pkg::SOFT_SLEEP_N_BIT])
               begin
                  next_control = led_ctrl_pkg::RST_DEVICE_CONTROL;
                  next_spreadCfg = led_ctrl_pkg::RST_SPREAD_CONFIG;
                  next_dutyHigh = led_ctrl_pkg::RST_DUTY;
                  next_dutyLow = led_ctrl_pkg::RST_DUTY;
               end
            default: next_control = control;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state <= ST_IDLE;
         shiftReg <= 8'h00;
         regPtr <= 8'h00;
         bitCnt <= 4'h0;
         readMode <= 1'b0;
         nack <= 1'b0;
         sdaOeN <= 1'b1;
         control <= led_ctrl_pkg::RST_DEVICE_CONTROL;
         spreadCfg <= led_ctrl_pkg::RST_SPREAD_CONFIG;
         dutyHigh <= led_ctrl_pkg::RST_DUTY;
         dutyLow <= led_ctrl_pkg::RST_DUTY;
      end
      else if (clkEn)
      begin
         state <= next_state;
         shiftReg <= next_shiftReg;
         regPtr <= next_regPtr;
         bitCnt <= next_bitCnt;
         readMode <= next_readMode;
         nack <= next_nack;
         sdaOeN <= next_sdaOeN;
         control <= next_control;
         spreadCfg <= next_spreadCfg;
         dutyHigh <= next_dutyHigh;
         dutyLow <= next_dutyLow;
      end
   end

   assign sdaOut = 1'b0;

   // ----------------------------------------------------------------
   // Shutdown, PWM and spread sweep
   // ----------------------------------------------------------------
   logic [15:0] pwmCnt, next_pwmCnt, pwmMax;
   logic [23:0] stepCnt, next_stepCnt, stepLen;
   logic [7:0] next_sweepPhase;
   logic sweepUp, next_sweepUp, ledOn, next_pwmOut, next_spreadActive;

   assign ledOn = pinHigh & control[led_ctrl_pkg::SOFT_SLEEP_N_BIT];

   // Resolution picks the counter wrap; duty compares linearly against the count.
   always_comb
   begin
      case (control[led_ctrl_pkg::RES_SEL_LSB +: 2])
         2'h0: pwmMax = 16'h00ff;
         2'h1: pwmMax = 16'h03ff;
         2'h2: pwmMax = 16'h0fff;
         default: pwmMax = 16'hffff;
      endcase
      next_pwmCnt = (pwmCnt >= pwmMax) ? 16'h0000 : pwmCnt + 16'h0001;
      next_pwmOut = ledOn & ({dutyHigh, dutyLow} > pwmCnt);
   end

   // Sweep step length divides the selected period into triangle steps.
   always_comb
   begin
      case (spreadCfg[led_ctrl_pkg::CYCLE_SEL_LSB +: 2])
         2'h0: stepLen = 24'(SPREAD_T0_CYCLES / led_ctrl_pkg::SWEEP_STEPS);
         2'h1: stepLen = 24'(SPREAD_T1_CYCLES / led_ctrl_pkg::SWEEP_STEPS);
         2'h2: stepLen = 24'(SPREAD_T2_CYCLES / led_ctrl_pkg::SWEEP_STEPS);
         default: stepLen = 24'(SPREAD_T3_CYCLES / led_ctrl_pkg::SWEEP_STEPS);
      endcase
      next_spreadActive = pinHigh & spreadCfg[led_ctrl_pkg::SPREAD_EN_BIT];
      next_stepCnt = stepCnt;
      next_sweepPhase = sweepPhase;
      next_sweepUp = sweepUp;
      if (!spreadActive)
      begin
         next_stepCnt = 24'h000000;
         next_sweepPhase = led_ctrl_pkg::SWEEP_CENTER;
         next_sweepUp = 1'b1;
      end
      else if (stepCnt + 24'h000001 >= stepLen)
      begin
         next_stepCnt = 24'h000000;
         next_sweepUp = sweepUp ? (sweepPhase != 8'hfe) : (sweepPhase == 8'h01);
         next_sweepPhase = sweepUp ? sweepPhase + 8'h01 : sweepPhase - 8'h01;
      end
      else
         next_stepCnt = stepCnt + 24'h000001;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         pwmCnt <= 16'h0000;
         pwmOut <= 1'b0;
         ledEnable <= 1'b0;
         analogEnable <= 1'b0;
         spreadActive <= 1'b0;
         spreadRange <= 2'h0;
         stepCnt <= 24'h000000;
         sweepPhase <= led_ctrl_pkg::SWEEP_CENTER;
         sweepUp <= 1'b1;
      end
      else if (clkEn)
      begin
         pwmCnt <= next_pwmCnt;
         pwmOut <= next_pwmOut;
         ledEnable <= ledOn;
         analogEnable <= pinHigh;
         spreadActive <= next_spreadActive;
         spreadRange <= spreadCfg[led_ctrl_pkg::RANGE_SEL_LSB +: 2];
         stepCnt <= next_stepCnt;
         sweepPhase <= next_sweepPhase;
         sweepUp <= next_sweepUp;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_pwm_dark_off: assert property (clkEn && !ledOn |=> !pwmOut)
      else $error("PWM active during shutdown");
   a_led_both_on: assert property (clkEn |=> ledEnable == $past(ledOn))
      else $error("LED enable does not follow shutdown state");
   a_analog_pin_low: assert property (clkEn && !pdSync[1] |=> !analogEnable)
      else $error("Analog enabled while pin low");
   a_pin_rise_idle: assert property (clkEn && pdRise |=> state == ST_IDLE)
      else $error("Pin rise did not reset bus engine");
   a_pin_keeps_regs: assert property (clkEn && pdRise |=>
      $stable(control) && $stable(spreadCfg))
      else $error("Registers changed on pin rise");
   a_sweep_center: assert property (clkEn && !spreadActive |=> sweepPhase == 8'h80)
      else $error("Sweep moving while spread disabled");
   a_soft_sleep_wr: assert property (clkEn && wrStrobe && regPtr == 8'h00
      && !shiftReg[0] |=> ##[1:3] !ledEnable)
      else $error("Soft sleep write did not darken outputs");
   a_reset_cmd: assert property (clkEn && wrStrobe && regPtr == 8'h7f
      && shiftReg == 8'h00 && pinHigh && control[0] |=> control == 8'h00 && spreadCfg == 8'h00)
      else $error("Reset command did not restore defaults");
   a_pwm_linear: assert property (clkEn && ledOn && {dutyHigh, dutyLow} == 16'h0004
      && pwmCnt == 16'h0003 |=> pwmOut)
      else $error("Duty four not on at fourth count");
   a_range_follow: assert property (clkEn |=> spreadRange == $past(spreadCfg[3:2]))
      else $error("Range output lags configuration");

   c_soft_sleep: cover property (wrStrobe && regPtr == 8'h00);
   c_reset_cmd: cover property (wrStrobe && regPtr == 8'h7f);
   c_pin_rise: cover property (pdRise);
   c_read_byte: cover property (state == ST_RACK);
endmodule

// ==== tb/i2c_host_model.sv ====
// Two-wire bus controller model that drives the serial pins of the block.
// Assumes a pull-up on the data line and that the block only ever pulls it low.
`timescale 1ns/1ps
module i2c_host_model
#(
   parameter logic [6:0] ADDR = led_ctrl_pkg::DEFAULT_BUS_ADDR,
   parameter int PH = 6
)
(
   input wire logic mclk,
   input wire logic sdaOut,
   input wire logic sdaOeN,
   output logic scl,
   output logic sdaLine
);
   // ------------------------------
   // Wire and bit timing
   // ------------------------------
   logic hostSda = 1'b1;
   // The pull-up wins unless a party pulls low, so a released line never shows stale data.
   assign sdaLine = hostSda & (sdaOeN | sdaOut);
   initial scl = 1'b1;
   // Each phase lasts PH clocks, above the three the block needs to see it.
   task automatic tick();
      repeat (PH) @(posedge mclk);
      #1;
   endtask
   task automatic bitIo(input logic b, output logic s);
      hostSda = b;
      tick();
      scl = 1'b1;
      tick();
      s = sdaLine;
      scl = 1'b0;
   endtask
   // Eight bits MSB first, then the ninth; a released bit reads back the far side.
   task automatic byteIo(input logic [7:0] d, input logic m, output logic [7:0] q,
      output logic ack);
      for (int i = 7; i >= 0; i--)
         bitIo(d[i], q[i]);
      bitIo(m, ack);
   endtask
   task automatic busStart();
      hostSda = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      hostSda = 1'b0;
      tick();
      scl = 1'b0;
   endtask
   task automatic busStop();
      hostSda = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      hostSda = 1'b1;
      tick();
   endtask
   // ------------------------------
   // Register transfers
   // ------------------------------
   task automatic writeReg(input logic [7:0] ofs, input logic [7:0] d, output logic nack);
      logic [7:0] q;
      logic a0, a1, a2;
      busStart();
      byteIo({ADDR, 1'b0}, 1'b1, q, a0);
      byteIo(ofs, 1'b1, q, a1);
      byteIo(d, 1'b1, q, a2);
      busStop();
      nack = a0 | a1 | a2;
   endtask
   // Pointer first, then a repeated start and one byte read closed by a NACK.
   task automatic readReg(input logic [7:0] ofs, output logic [7:0] d, output logic nack);
      logic [7:0] q;
      logic a0, a1, a2, m;
      busStart();
      byteIo({ADDR, 1'b0}, 1'b1, q, a0);
      byteIo(ofs, 1'b1, q, a1);
      busStart();
      byteIo({ADDR, 1'b1}, 1'b1, q, a2);
      byteIo(8'hff, 1'b1, d, m);
      busStop();
      nack = a0 | a1 | a2;
   endtask
endmodule

// ==== tb/led_mode_ctrl_test.sv ====
// Self-checking bench for the mode, shutdown and spread control block.
// Assumes the host model above and short spread periods set below.
`timescale 1ns/1ps
module led_mode_ctrl_test;
   // ------------------------------
   // Clock, reset and instances
   // ------------------------------
   localparam int PER[4] = '{4096, 3072, 2048, 1024};
   localparam int WIN = 480;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic pinN = 1'b1;
   logic clkEn = 1'b1;
   logic sclIn, sdaIn, sdaOut, sdaOeN, analogEnable, ledEnable, pwmOut, spreadActive;
   logic [1:0] spreadRange;
   logic [7:0] sweepPhase;
   int errCount = 0;
   int totalChecks = 0;
   int seed = 83;
   int cycles = 0;
   always #25 mclk = ~mclk;
   led_mode_ctrl #(.SPREAD_T0_CYCLES(PER[0]), .SPREAD_T1_CYCLES(PER[1]),
      .SPREAD_T2_CYCLES(PER[2]), .SPREAD_T3_CYCLES(PER[3])) i_dut (.mclk(mclk),
      .reset(reset), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
      .sdaOeN(sdaOeN), .hw_power_down_n(pinN), .analogEnable(analogEnable),
      .ledEnable(ledEnable), .pwmOut(pwmOut), .spreadActive(spreadActive),
      .spreadRange(spreadRange), .sweepPhase(sweepPhase));
   i2c_host_model i_host (.mclk(mclk), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .scl(sclIn),
      .sdaLine(sdaIn));
   // ------------------------------
   // Helpers
   // ------------------------------
   task automatic reportAndStop();
      if (errCount == 0 && totalChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // A hung run counts as a mismatch and ends through the same report.
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles > 98000)
      begin
         errCount++;
         reportAndStop();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         errCount++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      logic a;
      i_host.writeReg(ofs, d, a);
      check("write ack", 16'(a), 16'h0);
   endtask
   task automatic rdChk(input logic [7:0] ofs, input logic [7:0] exp);
      logic [7:0] d;
      logic a;
      i_host.readReg(ofs, d, a);
      check("read ack", 16'(a), 16'h0);
      check("read data", 16'(d), 16'(exp));
   endtask
   // Counts pwm high cycles, or sweep phase changes, over a window.
   task automatic count(input int n, input bit sweep, output int k);
      logic [7:0] p;
      p = sweepPhase;
      k = 0;
      repeat (n)
      begin
         cyc(1);
         k += sweep ? int'(sweepPhase !== p) : int'(pwmOut === 1'b1);
         p = sweepPhase;
      end
   endtask
   function automatic int resBits(input int c);
      return (c == 3) ? 16 : 8 + 2 * c;
   endfunction
   function automatic int expSteps(input int c);
      return WIN * 512 / PER[c];
   endfunction
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial
   begin
      int k;
      logic [7:0] v;
      logic a;
      logic [7:0] q;
      repeat (3) @(posedge mclk);
      #1 reset = 1'b0;
      cyc(6);
      check("ledEnable", 16'(ledEnable), 16'h0);
      check("sweepPhase", 16'(sweepPhase), 16'h80);
      rdChk(8'h00, 8'h00);
      rdChk(8'h78, 8'h00);
      rdChk(8'h50, 8'h00);
      // Every resolution with duty four gives four high counts per period.
      wr(8'h01, 8'h00);
      wr(8'h02, 8'h04);
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h00, {5'h0, 2'(c), 1'b1});
         cyc(4);
         check("ledEnable", 16'(ledEnable), 16'h1);
         count(1 << resBits(c), 0, k);
         check("pwm high", 16'(k), 16'h4);
      end
      v = 8'($random(seed));
      wr(8'h00, 8'h01);
      wr(8'h02, v);
      cyc(4);
      count(256, 0, k);
      check("pwm random", 16'(k), 16'(v));
      wr(8'h00, 8'h00);
      cyc(4);
      check("ledEnable", 16'(ledEnable), 16'h0);
      count(256, 0, k);
      check("pwm dark", 16'(k), 16'h0);
      rdChk(8'h02, v);
      // Random spread settings with every range forced in turn.
      for (int i = 0; i < 8; i++)
      begin
         v = 8'($random(seed));
         v[3:2] = 2'(i);
         wr(8'h78, v);
         cyc(3);
         check("spreadActive", 16'(spreadActive), 16'(v[4]));
         check("spreadRange", 16'(spreadRange), 16'(v[3:2]));
      end
      // Sweep step rate per cycle code, and a frozen sweep when disabled.
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h78, {4'h1, 2'b00, 2'(c)});
         cyc(8);
         count(WIN, 1, k);
         k = k - expSteps(c);
         check("sweep rate", 16'(k >= -2 && k <= 2), 16'h1);
      end
      // A low clock enable must freeze the fastest sweep in place.
      v = sweepPhase;
      clkEn = 1'b0;
      cyc(20);
      check("frozen sweep", 16'(sweepPhase), 16'(v));
      clkEn = 1'b1;
      wr(8'h78, 8'h0c);
      cyc(8);
      count(WIN, 1, k);
      check("sweep off", 16'(k), 16'h0);
      check("sweepPhase", 16'(sweepPhase), 16'h80);
      // Pin low: analog off, outputs dark, bus still usable.
      wr(8'h00, 8'h01);
      wr(8'h78, 8'h13);
      pinN = 1'b0;
      cyc(6);
      check("analogEnable", 16'(analogEnable), 16'h0);
      check("ledEnable", 16'(ledEnable), 16'h0);
      check("spreadActive", 16'(spreadActive), 16'h0);
      wr(8'h78, 8'h1e);
      rdChk(8'h78, 8'h1e);
      // A pin rise in mid-transfer drops the transfer but keeps registers.
      i_host.busStart();
      i_host.byteIo({led_ctrl_pkg::DEFAULT_BUS_ADDR, 1'b0}, 1'b1, q, a);
      check("addr ack", 16'(a), 16'h0);
      pinN = 1'b1;
      cyc(8);
      i_host.byteIo(8'h78, 1'b1, q, a);
      check("aborted ack", 16'(a), 16'h1);
      i_host.busStop();
      check("analogEnable", 16'(analogEnable), 16'h1);
      check("ledEnable", 16'(ledEnable), 16'h1);
      check("spreadRange", 16'(spreadRange), 16'h3);
      rdChk(8'h78, 8'h1e);
      // Reset command is refused in either shutdown and obeyed otherwise.
      wr(8'h00, 8'h00);
      wr(8'h7f, 8'h00);
      rdChk(8'h78, 8'h1e);
      wr(8'h00, 8'h01);
      pinN = 1'b0;
      cyc(6);
      wr(8'h7f, 8'h00);
      rdChk(8'h78, 8'h1e);
      pinN = 1'b1;
      cyc(8);
      wr(8'h7f, 8'h00);
      rdChk(8'h78, 8'h00);
      rdChk(8'h00, 8'h00);
      reportAndStop();
   end
endmodule
